// [hdl/pss_top.sv]
`timescale 1ns/1ps
`include "pss_cfg.svh"
// Summary of operation
// - code 010 divides 2/3, 2 if A zero
// - code 011 divides 4/5, 4 if A zero
// - code 100 divides 8/9, 8 if A zero
// - code 101 divides 16/17, 16 if zero
// - code 110 divides 32/33, 32 if zero
// - codes 1..6 route divider and detector signals
// - other low codes drive status low
// - high codes mirror monitor set, 100000 and 101111 up low
// - 100001 first or differential reference
// - 100010 second reference, void if differential
// - 100011 used reference, 100100 unused one
// - 100101 selected reference status, high
// - 100110 unselected reference status, high
// - 100111/101000 reference frequency flags
// - 101001 AND of both frequency flags
// - 101010 lock AND selected AND vco
// - 101011 vco frequency status flag
// - 101100 low first, high second reference
// - 101101 digital lock flag, active high
// - 101110 high while holdover active
// - swallow count is six bits
module pss_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        presc_tick,
  input  wire logic        fb_div_out,
  input  wire logic        ref_div_out,
  input  wire logic        pfd_up,
  input  wire logic        pfd_down,
  input  wire logic        first_reference,
  input  wire logic        second_reference,
  input  wire logic        diff_reference,
  input  wire logic        second_selected,
  input  wire logic        sel_ref_ok,
  input  wire logic        unsel_ref_ok,
  input  wire logic        first_reference_freq_ok,
  input  wire logic        second_reference_freq_ok,
  input  wire logic        vco_freq_ok,
  input  wire logic        digital_lock_flag,
  input  wire logic        holdover_active,
  output logic             status_pin,
  output logic             presc_out,
  output logic             swallow_out
);

  // ****************************************
  // declarations
  // ****************************************
  pss_pkg::pss_ssel_t  sel_ff;
  pss_pkg::pss_mod_t   acnt_ff;
  pss_pkg::pss_pcode_t pcode_ff;
  logic                diff_ff;
  pss_pkg::pss_mod_t   cnt_ff;
  pss_pkg::pss_mod_t   swc_ff;
  pss_pkg::pss_mod_t   base_w;
  pss_pkg::pss_mod_t   mod_w;
  logic                dm_w;
  logic                last_w;
  logic                step_w;
  logic                presc_ff;
  logic                swo_ff;
  logic                status_ff;
  logic                nxt_status;
  logic [31:0]         prdata_ff;
  logic [31:0]         nxt_prdata;
  logic                perr_ff;
  logic                nxt_perr;
  logic                wr_w;
  logic [2:0]          ref_raw;
  logic [2:0]          ref_s1_ff;
  logic [2:0]          ref_s2_ff;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input pss_pkg::pss_idx_t idx);
    hit = (a[1:0] == 2'h0) && (a[7:2] == idx);
  endfunction

  function automatic pss_pkg::pss_mod_t base_mod(input pss_pkg::pss_pcode_t c);
    case (c)
      `PSS_PRE_FD1:  base_mod = 6'h01;
      `PSS_PRE_FD2:  base_mod = 6'h02;
      `PSS_PRE_DM2:  base_mod = 6'h02;
      `PSS_PRE_DM4:  base_mod = 6'h04;
      `PSS_PRE_DM8:  base_mod = 6'h08;
      `PSS_PRE_DM16: base_mod = 6'h10;
      `PSS_PRE_DM32: base_mod = 6'h20;
      default:       base_mod = 6'h03;
    endcase
  endfunction

  // ****************************************
  // reference clock synchronisers
  // ****************************************
  assign ref_raw = {diff_reference, second_reference, first_reference};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ref_s1_ff[gi] <= 1'b0;
          ref_s2_ff[gi] <= 1'b0;
        end else if (ce) begin
          ref_s1_ff[gi] <= ref_raw[gi];
          ref_s2_ff[gi] <= ref_s1_ff[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // apb slave
  // ****************************************
  assign pready  = ce;
  assign prdata  = prdata_ff;
  assign pslverr = perr_ff;
  assign wr_w    = ce && psel && penable && pwrite && !perr_ff;

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_perr   = 1'b0;
    if (hit(paddr, `PSS_IDX_STSEL)) begin
      nxt_prdata[`PSS_STSEL_MSB:`PSS_STSEL_LSB] = sel_ff;
    end else if (hit(paddr, `PSS_IDX_ACNT)) begin
      nxt_prdata[5:0] = acnt_ff;
    end else if (hit(paddr, `PSS_IDX_PRESC)) begin
      nxt_prdata[2:0] = pcode_ff;
    end else if (hit(paddr, `PSS_IDX_CFG)) begin
      nxt_prdata[0] = diff_ff;
    end else if (hit(paddr, `PSS_IDX_STATE)) begin
      nxt_prdata = {10'h000, mod_w, 2'h0, swc_ff, 6'h00, presc_ff, status_ff};
    end else begin
      nxt_perr = 1'b1;
    end
  end

  // response captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      perr_ff   <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata_ff <= nxt_prdata;
      perr_ff   <= nxt_perr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff   <= `PSS_RST_STSEL;
      acnt_ff  <= `PSS_RST_ACNT;
      pcode_ff <= `PSS_RST_PRESC;
      diff_ff  <= `PSS_RST_DIFF;
    end else if (wr_w) begin
      if (hit(paddr, `PSS_IDX_STSEL)) begin
        sel_ff <= pwdata[`PSS_STSEL_MSB:`PSS_STSEL_LSB];
      end else if (hit(paddr, `PSS_IDX_ACNT)) begin
        acnt_ff <= pwdata[5:0];
      end else if (hit(paddr, `PSS_IDX_PRESC)) begin
        pcode_ff <= pwdata[2:0];
      end else if (hit(paddr, `PSS_IDX_CFG)) begin
        diff_ff <= pwdata[0];
      end
    end
  end

  // ****************************************
  // prescaler
  // ****************************************
  assign base_w = base_mod(pcode_ff);
  assign dm_w   = (pcode_ff != `PSS_PRE_FD1) && (pcode_ff != `PSS_PRE_FD2) &&
                  (pcode_ff != `PSS_PRE_FD3);
  // dual modulus: A periods of base+1, then one of base
  assign mod_w  = (dm_w && (acnt_ff != 6'h00) && (swc_ff < acnt_ff)) ?
                  base_w + 6'h01 : base_w;
  // >= keeps a shrunk modulus from running away
  assign last_w = cnt_ff >= (mod_w - 6'h01);
  assign step_w = ce && presc_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 6'h00;
    end else if (step_w) begin
      cnt_ff <= last_w ? 6'h00 : cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swc_ff <= 6'h00;
    end else if (step_w && last_w) begin
      if (!dm_w || swc_ff >= acnt_ff) begin
        swc_ff <= 6'h00;
      end else begin
        swc_ff <= swc_ff + 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_ff <= 1'b0;
      swo_ff   <= 1'b0;
    end else if (ce) begin
      presc_ff <= presc_tick && last_w;
      swo_ff   <= presc_tick && last_w && dm_w && (acnt_ff != 6'h00) &&
                  (swc_ff >= acnt_ff);
    end
  end

  assign presc_out   = presc_ff;
  assign swallow_out = swo_ff;

  // ****************************************
  // status pin select
  // ****************************************
  // divider and detector codes follow the live signal, reference codes the synchronised copy, level codes the flag
  always_comb begin
    nxt_status = 1'b0;
    case (sel_ff)
      `PSS_ST_NDIV:   nxt_status = fb_div_out;
      `PSS_ST_RDIV:   nxt_status = ref_div_out;
      `PSS_ST_ADIV:   nxt_status = swo_ff;
      `PSS_ST_PRESC:  nxt_status = presc_ff;
      `PSS_ST_PFDUP:  nxt_status = pfd_up;
      `PSS_ST_PFDDN:  nxt_status = pfd_down;
      `PSS_ST_FIRST_REFERENCE:   nxt_status = diff_ff ? ref_s2_ff[2] : ref_s2_ff[0];
      `PSS_ST_SECOND_REFERENCE:   nxt_status = !diff_ff && ref_s2_ff[1];
      `PSS_ST_SELREF: begin
        nxt_status = diff_ff ? ref_s2_ff[2] :
                     (second_selected ? ref_s2_ff[1] : ref_s2_ff[0]);
      end
      `PSS_ST_UNSREF: begin
        nxt_status = !diff_ff &&
                     (second_selected ? ref_s2_ff[0] : ref_s2_ff[1]);
      end
      `PSS_ST_SELOK:  nxt_status = sel_ref_ok;
      `PSS_ST_UNSOK:  nxt_status = !diff_ff && unsel_ref_ok;
      `PSS_ST_R1FRQ:  nxt_status = first_reference_freq_ok;
      `PSS_ST_R2FRQ:  nxt_status = second_reference_freq_ok;
      `PSS_ST_RFAND:  nxt_status = first_reference_freq_ok && second_reference_freq_ok;
      `PSS_ST_LKAND:  nxt_status = digital_lock_flag && sel_ref_ok && vco_freq_ok;
      `PSS_ST_VCO:    nxt_status = vco_freq_ok;
      `PSS_ST_WHICH:  nxt_status = second_selected;
      `PSS_ST_LOCK:   nxt_status = digital_lock_flag;
      `PSS_ST_HOLD:   nxt_status = holdover_active;
      default:        nxt_status = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= 1'b0;
    end else if (ce) begin
      status_ff <= nxt_status;
    end
  end

  assign status_pin = status_ff;

  // ****************************************
  // checks
  // ****************************************
  chk_fd_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    !dm_w |-> mod_w == ((pcode_ff == `PSS_PRE_FD1) ? 6'h01 :
                        (pcode_ff == `PSS_PRE_FD2) ? 6'h02 : 6'h03))
    else $error("fixed divide ratio wrong");
  chk_dm_two: assert property (@(posedge pclk) disable iff (!presetn)
    pcode_ff == `PSS_PRE_DM2 |->
      mod_w == ((acnt_ff != 6'h00 && swc_ff < acnt_ff) ? 6'h03 : 6'h02))
    else $error("divide 2/3 wrong");
  chk_dm_four: assert property (@(posedge pclk) disable iff (!presetn)
    pcode_ff == `PSS_PRE_DM4 |->
      mod_w == ((acnt_ff != 6'h00 && swc_ff < acnt_ff) ? 6'h05 : 6'h04))
    else $error("divide 4/5 wrong");
  chk_dm_eight: assert property (@(posedge pclk) disable iff (!presetn)
    pcode_ff == `PSS_PRE_DM8 |->
      mod_w == ((acnt_ff != 6'h00 && swc_ff < acnt_ff) ? 6'h09 : 6'h08))
    else $error("divide 8/9 wrong");
  chk_dm_sixteen: assert property (@(posedge pclk) disable iff (!presetn)
    pcode_ff == `PSS_PRE_DM16 |->
      mod_w == ((acnt_ff != 6'h00 && swc_ff < acnt_ff) ? 6'h11 : 6'h10))
    else $error("divide 16/17 wrong");
  chk_dm_thirtytwo: assert property (@(posedge pclk) disable iff (!presetn)
    pcode_ff == `PSS_PRE_DM32 |->
      mod_w == ((acnt_ff != 6'h00 && swc_ff < acnt_ff) ? 6'h21 : 6'h20))
    else $error("divide 32/33 wrong");
  chk_swallow_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    step_w && last_w && swc_ff >= acnt_ff |=> swc_ff == 6'h00)
    else $error("swallow count did not wrap");
  chk_st_fbdiv: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sel_ff == `PSS_ST_NDIV |=> status_ff == $past(fb_div_out))
    else $error("status not feedback divider");
  chk_st_ground: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !sel_ff[5] && (sel_ff == 6'h00 || sel_ff > `PSS_ST_PFDDN) |=> !status_ff)
    else $error("status not grounded");
  chk_st_first_reference: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sel_ff == `PSS_ST_FIRST_REFERENCE |=>
      status_ff == $past(diff_ff ? ref_s2_ff[2] : ref_s2_ff[0]))
    else $error("status not first reference");
  chk_st_lockand: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sel_ff == `PSS_ST_LKAND |=>
      status_ff == $past(digital_lock_flag && sel_ref_ok && vco_freq_ok))
    else $error("lock AND wrong");
  chk_st_which: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sel_ff == `PSS_ST_WHICH |=> status_ff == $past(second_selected))
    else $error("reference in use wrong");
  chk_st_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sel_ff == `PSS_ST_HOLD |=> status_ff == $past(holdover_active))
    else $error("holdover flag wrong");

endmodule

// [hdl/pss_cfg.svh]
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH
// register indices, byte address is four times the index
`define PSS_IDX_STSEL  6'h07
`define PSS_IDX_ACNT   6'h13
`define PSS_IDX_PRESC  6'h16
`define PSS_IDX_CFG    6'h1C
`define PSS_IDX_STATE  6'h1D
// reset values
`define PSS_RST_STSEL  6'h00
`define PSS_RST_ACNT   6'h00
`define PSS_RST_PRESC  3'h0
`define PSS_RST_DIFF   1'b0
// field positions
`define PSS_STSEL_LSB  2
`define PSS_STSEL_MSB  7
// prescaler codes
`define PSS_PRE_FD1    3'h0
`define PSS_PRE_FD2    3'h1
`define PSS_PRE_DM2    3'h2
`define PSS_PRE_DM4    3'h3
`define PSS_PRE_DM8    3'h4
`define PSS_PRE_DM16   3'h5
`define PSS_PRE_DM32   3'h6
`define PSS_PRE_FD3    3'h7
// status pin select codes
`define PSS_ST_NDIV    6'h01
`define PSS_ST_RDIV    6'h02
`define PSS_ST_ADIV    6'h03
`define PSS_ST_PRESC   6'h04
`define PSS_ST_PFDUP   6'h05
`define PSS_ST_PFDDN   6'h06
`define PSS_ST_FIRST_REFERENCE    6'h21
`define PSS_ST_SECOND_REFERENCE    6'h22
`define PSS_ST_SELREF  6'h23
`define PSS_ST_UNSREF  6'h24
`define PSS_ST_SELOK   6'h25
`define PSS_ST_UNSOK   6'h26
`define PSS_ST_R1FRQ   6'h27
`define PSS_ST_R2FRQ   6'h28
`define PSS_ST_RFAND   6'h29
`define PSS_ST_LKAND   6'h2A
`define PSS_ST_VCO     6'h2B
`define PSS_ST_WHICH   6'h2C
`define PSS_ST_LOCK    6'h2D
`define PSS_ST_HOLD    6'h2E
`endif

// [hdl/pss_pkg.sv]
package pss_pkg;
  typedef logic [2:0] pss_pcode_t;
  typedef logic [5:0] pss_mod_t;
  typedef logic [5:0] pss_ssel_t;
  typedef logic [5:0] pss_idx_t;
endpackage

// [tb/pss_pin_watch.sv]
`timescale 1ns/1ps
// *****
// sampler at the far side of the status pin
// *****
module pss_pin_watch (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        status_pin,
  output logic             seen_level,
  output logic      [15:0] rise_count
);
  logic        last_ff;
  // pin taken as a plain level each cycle, edges counted for toggling codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ff    <= 1'b0;
      rise_count <= 16'h0000;
    end else begin
      last_ff <= status_pin;
      if (status_pin && !last_ff) begin
        rise_count <= rise_count + 16'h0001;
      end
    end
  end
  assign seen_level = last_ff;
endmodule

// [tb/prescaler_and_status_select_tb.sv]
`timescale 1ns/1ps
`include "pss_cfg.svh"
module prescaler_and_status_select_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        presc_tick = 1'b1;
  logic [14:0] src = 15'h0000;
  logic        status_pin;
  logic        presc_out;
  logic        swallow_out;
  logic        seen_level;
  logic [15:0] rises;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          per_tab [8] = '{1, 2, 2, 4, 8, 16, 32, 3};
  logic [14:0] pat [5] = '{15'h0000, 15'h7FFF, 15'h5555, 15'h2AAA, 15'h3D00};

  always #5 pclk = ~pclk;

  pss_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .presc_tick(presc_tick), .fb_div_out(src[0]), .ref_div_out(src[1]),
    .pfd_up(src[2]), .pfd_down(src[3]), .first_reference(src[4]),
    .second_reference(src[5]), .diff_reference(src[6]), .second_selected(src[7]),
    .sel_ref_ok(src[8]), .unsel_ref_ok(src[9]), .first_reference_freq_ok(src[10]),
    .second_reference_freq_ok(src[11]), .vco_freq_ok(src[12]), .digital_lock_flag(src[13]),
    .holdover_active(src[14]), .status_pin(status_pin), .presc_out(presc_out),
    .swallow_out(swallow_out));

  pss_pin_watch watch (.pclk(pclk), .presetn(presetn), .status_pin(status_pin),
    .seen_level(seen_level), .rise_count(rises));

  // *****
  // checking and bus tasks
  // *****
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d,
                     output logic [31:0] rd, output logic err, input logic [1:0] lo = 2'b00);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, lo};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, d, rd, err);
  endtask

  task automatic rd_chk(input string what, input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0000_0000, rd, err);
    check(what, rd, exp);
  endtask

  task automatic next_pulse(output int gap);
    gap = 0;
    do begin
      @(posedge pclk);
      gap++;
    end while (presc_out !== 1'b1 && gap < 100);
  endtask

  // expected pin level for a select code and source levels
  function automatic logic exp_pin(input logic [5:0] c, input logic [14:0] s, input logic df);
    logic sr;
    sr = df ? s[6] : (s[7] ? s[5] : s[4]);
    case (c)
      6'h01: return s[0];
      6'h02: return s[1];
      6'h04: return 1'b1;
      6'h05: return s[2];
      6'h06: return s[3];
      6'h21: return df ? s[6] : s[4];
      6'h22: return df ? 1'b0 : s[5];
      6'h23: return sr;
      6'h24: return df ? 1'b0 : (s[7] ? s[4] : s[5]);
      6'h25: return s[8];
      6'h26: return df ? 1'b0 : s[9];
      6'h27: return s[10];
      6'h28: return s[11];
      6'h29: return s[10] & s[11];
      6'h2A: return s[13] & s[8] & s[12];
      6'h2B: return s[12];
      6'h2C: return s[7];
      6'h2D: return s[13];
      6'h2E: return s[14];
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    complete_run();
  end

  // *****
  // test sequence
  // *****
  initial begin
    logic [31:0] rd;
    logic        err;
    int          g;
    int          p;
    logic        dm;
    string       nm;
    logic [31:0] exp_v;
    logic [31:0] seen_v;
    logic [15:0] r0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("select reset", `PSS_IDX_STSEL, 32'h0000_0000);
    rd_chk("swallow reset", `PSS_IDX_ACNT, 32'h0000_0000);
    rd_chk("presc reset", `PSS_IDX_PRESC, 32'h0000_0000);
    wr(`PSS_IDX_ACNT, 32'hFFFF_FFFF);
    rd_chk("swallow width", `PSS_IDX_ACNT, 32'h0000_003F);
    wr(`PSS_IDX_STSEL, 32'hFFFF_FFFF);
    rd_chk("select field", `PSS_IDX_STSEL, 32'h0000_00FC);
    apb(1'b0, 6'h00, 32'h0000_0000, rd, err);
    check("unmapped err", {31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, `PSS_IDX_STSEL, 32'h0000_0000, rd, err, 2'b01);
    check("misaligned err", {31'h0000_0000, err}, 32'h0000_0001);
    rd_chk("select kept", `PSS_IDX_STSEL, 32'h0000_00FC);
    ce <= 1'b0;
    @(posedge pclk);
    check("stalled ready", {31'h0000_0000, pready}, 32'h0000_0000);
    ce <= 1'b1;
    wr(`PSS_IDX_ACNT, 32'h0000_0000);
    wr(`PSS_IDX_PRESC, 32'h0000_0000);
    for (int df = 0; df < 2; df++) begin
      wr(`PSS_IDX_CFG, df);
      for (int c = 0; c < 64; c++) begin
        wr(`PSS_IDX_STSEL, c << 2);
        for (int k = 0; k < 5; k++) begin
          src <= pat[k];
          repeat (6) @(posedge pclk);
          nm = $sformatf("pin code %h diff %0d pat %0d", c, df, k);
          exp_v = {31'h0, exp_pin(c[5:0], pat[k], df[0])};
          seen_v = {31'h0, seen_level};
          if (c < 32) begin
            check(nm, seen_v, exp_v);
          end else if (c < 36) begin
            check(nm, seen_v, exp_v);
          end else if (c < 39) begin
            check(nm, seen_v, exp_v);
          end else if (c < 42) begin
            check(nm, seen_v, exp_v);
          end else begin
            check(nm, seen_v, exp_v);
          end
        end
      end
    end
    // prescaler output on the pin, divide by 2: one rise every 2 cycles
    wr(`PSS_IDX_PRESC, 32'h0000_0001);
    wr(`PSS_IDX_STSEL, 32'h0000_0010);
    repeat (8) @(posedge pclk);
    r0 = rises;
    repeat (20) @(posedge pclk);
    check("toggling rises", {16'h0000, rises - r0}, 32'h0000_000A);
    src <= 15'h0000;
    for (int k = 0; k < 8; k++) begin
      p = per_tab[k];
      dm = (k >= 2 && k <= 6);
      wr(`PSS_IDX_PRESC, k);
      wr(`PSS_IDX_ACNT, 32'h0000_0002);
      g = 0;
      if (dm) begin
        while (swallow_out !== 1'b1) begin
          @(posedge pclk);
        end
      end else begin
        next_pulse(g);
      end
      for (int j = 0; j < 3; j++) begin
        next_pulse(g);
        nm = $sformatf("gap code %0d a2 #%0d", k, j);
        exp_v = (dm && j < 2) ? p + 1 : p;
        check(nm, g, exp_v);
      end
      if (dm) begin
        seen_v = {31'h0, swallow_out};
        check("swallow end", seen_v, 32'h0000_0001);
      end
      wr(`PSS_IDX_ACNT, 32'h0000_0000);
      next_pulse(g);
      for (int j = 0; j < 2; j++) begin
        next_pulse(g);
        nm = $sformatf("gap code %0d a0", k);
        check(nm, g, p);
      end
    end
    complete_run();
  end
endmodule
